//--- hw/cwd_pkg.sv
// Constants for the configuration word decoder: field positions,
// reset values, register indices and decode codes.
// Assumes 14-bit configuration words from the nonvolatile store.
package cwd_pkg;
  localparam int CWD_WORD_W = 14;
  localparam int CWD_ADDR_W = 3;
  localparam int CWD_PM_AW = 13;
  // Register indices on the plain port
  localparam logic [2:0] CWD_REG_SUP = 3'h0;
  localparam logic [2:0] CWD_REG_MEM = 3'h1;
  localparam logic [2:0] CWD_REG_CP = 3'h2;
  localparam logic [2:0] CWD_REG_CTRL = 3'h3;
  localparam logic [2:0] CWD_REG_KEY = 3'h4;
  localparam logic [2:0] CWD_REG_STAT = 3'h5;
  // Unimplemented positions, forced to one
  localparam logic [13:0] CWD_SUP_UNIMP = 14'h0510;
  localparam logic [13:0] CWD_MEM_UNIMP = 14'h1FFC;
  localparam logic [13:0] CWD_CP_UNIMP = 14'h3FFC;
  // Supervisor word fields
  localparam int CWD_DEBUG_B = 13;
  localparam int CWD_STACK_B = 12;
  localparam int CWD_ONCE_B = 11;
  localparam int CWD_BORLVL_B = 9;
  localparam int CWD_BORMODE_B = 6;
  localparam int CWD_LPBOR_B = 5;
  localparam int CWD_WDT_B = 2;
  localparam int CWD_POWERUP_TIMER_B = 1;
  localparam int CWD_MASTER_CLEAR_PIN_B = 0;
  // Memory and code-protect word fields
  localparam int CWD_LVP_B = 13;
  localparam int CWD_WRT_B = 0;
  localparam int CWD_CPD_B = 1;
  localparam int CWD_CPF_B = 0;
  // Brown-out mode codes and the watchdog always-on code
  localparam logic [1:0] CWD_BOR_ON = 2'h3;
  localparam logic [1:0] CWD_BOR_SLEEP = 2'h2;
  localparam logic [1:0] CWD_BOR_SW = 2'h1;
  localparam logic [1:0] CWD_BOR_OFF = 2'h0;
  localparam logic [1:0] CWD_WDT_ON = 2'h3;
  // Self-write protection codes and top of protected range
  localparam logic [1:0] CWD_WRT_OFF = 2'h3;
  localparam logic [1:0] CWD_WRT_BOOT = 2'h2;
  localparam logic [1:0] CWD_WRT_HALF = 2'h1;
  localparam logic [12:0] CWD_BOOT_TOP = 13'h01FF;
  localparam logic [12:0] CWD_HALF_TOP = 13'h0FFF;
  localparam logic [12:0] CWD_ALL_TOP = 13'h1FFF;
  // Unlock keys for the pin-map lock
  localparam logic [7:0] CWD_KEY1 = 8'h55;
  localparam logic [7:0] CWD_KEY2 = 8'hAA;
  // Control and status layout
  localparam int CWD_CTRL_SBOR_B = 0;
  localparam int CWD_CTRL_LOCK_B = 1;
  localparam int CWD_ST_OVF_B = 0;
  localparam int CWD_ST_UNF_B = 1;
  localparam int CWD_ST_LV_B = 2;
  localparam int CWD_ST_FRZ_B = 3;
  localparam int CWD_ST_PROG_B = 4;
  // Reset values
  localparam logic [13:0] CWD_WORD_RST = 14'h3FFF;
  localparam logic CWD_SBOR_RST = 1'b1;
  typedef enum logic {CWD_LOAD, CWD_RUN} cwd_state_e;
endpackage

//--- hw/cwd_top.sv
// Configuration word decoder: latches three configuration words after
// reset and drives supervisor, reset and memory-access controls.
// Assumes nonvolatile words stable at reset release; all inputs
// synchronous to clk.
// Functional notes
// - Debug bit 1 keeps programming pins as I/O; 0 gives them to debugger.
// - Stack-fault reset bit 1 lets stack overflow/underflow reset the device.
// - One-way bit 1: lock cleared once, set once, then frozen until reset.
// - One-way bit 0: lock changes freely, each needing the unlock sequence.
// - Brown-out level bit 1 picks low trip, 0 picks high 2.7V.
// - Mode 11 always on, 10 off in sleep, 00 off; software bit ignored.
// - Mode 01 follows the software brown-out enable bit only.
// - Low-power brown-out enable is active low.
// - Watchdog mode 11 keeps watchdog always on.
// - Power-up timer enable is active low.
// - Low-voltage programming on forces the reset pin to master clear.
// - Otherwise master-clear bit 1 gives reset, 0 gives port function.
// - LOW_VOLT_PROG_EN bit 0 needs high voltage entry; 1 accepts low-voltage entry.
// - Refuse clearing LOW_VOLT_PROG_EN bit during a low-voltage-entered session.
// - Self-write protect 11 none, 10 to 01FFh, 01 to 0FFFh, 00 all.
// - Self-write protection never blocks programming port writes.
// - Data EEPROM protection bit is active low.
// - Program memory protection bit is active low.
// - Unimplemented configuration bits read back as one.
// - Flash protect blocks external access, reads zero, CPU reads kept.
// - EEPROM protect blocks external access, reads zero, CPU kept.
// - Stack-fault reset sets overflow or underflow flag.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cwd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] nv_sup_word,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] nv_mem_word,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] nv_cp_word,
  input wire logic [cwd_pkg::CWD_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cwd_pkg::CWD_WORD_W-1:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic stack_ovf_evt,
  input wire logic stack_unf_evt,
  input wire logic prog_hv_entry,
  input wire logic prog_lv_entry,
  input wire logic prog_exit,
  input wire logic prog_cfg_wr,
  input wire logic [1:0] prog_cfg_sel,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] prog_cfg_data,
  input wire logic sw_wr_req,
  input wire logic [cwd_pkg::CWD_PM_AW-1:0] sw_wr_addr,
  input wire logic ext_rd_req,
  input wire logic ext_wr_req,
  input wire logic ext_space_ee,
  input wire logic [cwd_pkg::CWD_WORD_W-1:0] ext_rdata_in,
  output logic cfg_ready,
  output logic debug_pins_owned,
  output logic stack_fault_reset,
  output logic pin_map_lock,
  output logic brownout_level_sel,
  output logic brownout_enable,
  output logic ultra_low_power_brownout,
  output logic [1:0] watchdog_mode,
  output logic watchdog_always_on,
  output logic powerup_timer,
  output logic master_clear_pin_en,
  output logic prog_active,
  output logic cfg_wr_go,
  output logic cfg_wr_refused,
  output logic sw_wr_go,
  output logic sw_wr_blocked,
  output logic ext_wr_go,
  output logic ext_rvalid,
  output logic [cwd_pkg::CWD_WORD_W-1:0] ext_rdata
);
  import cwd_pkg::*;

  cwd_state_e state_q;
  logic [13:0] sup_q, mem_q, cp_q;
  logic sbor_q, key1_q, armed_q, cleared_q, frozen_q;
  logic ovf_q, unf_q, lv_sess_q;

  // Protection check for self-writes by the running program
  function automatic logic wp_hit(input logic [1:0] code,
                                  input logic [12:0] addr);
    if (code == CWD_WRT_OFF) wp_hit = 1'b0;
    else if (code == CWD_WRT_BOOT) wp_hit = (addr <= CWD_BOOT_TOP);
    else if (code == CWD_WRT_HALF) wp_hit = (addr <= CWD_HALF_TOP);
    else wp_hit = (addr <= CWD_ALL_TOP);
  endfunction

  logic run, low_volt_prog_en, once, flash_prot, ee_prot, ext_prot;
  logic [1:0] bor_mode;
  assign run = (state_q == CWD_RUN);
  assign low_volt_prog_en = mem_q[CWD_LVP_B];
  assign once = sup_q[CWD_ONCE_B];
  assign bor_mode = sup_q[CWD_BORMODE_B +: 2];
  assign flash_prot = ~cp_q[CWD_CPF_B];
  assign ee_prot = ~cp_q[CWD_CPD_B];
  assign ext_prot = ext_space_ee ? ee_prot : flash_prot;

  // Words are caught one edge after reset release, never under reset.
  // Sampling under reset would race the store's own power-up read;
  // one edge later the store output is guaranteed settled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CWD_LOAD;
      sup_q <= CWD_WORD_RST;
      mem_q <= CWD_WORD_RST;
      cp_q <= CWD_WORD_RST;
    end else if (state_q == CWD_LOAD) begin
      state_q <= CWD_RUN;
      sup_q <= nv_sup_word | CWD_SUP_UNIMP;
      mem_q <= nv_mem_word | CWD_MEM_UNIMP;
      cp_q <= nv_cp_word | CWD_CP_UNIMP;
    end
  end

  // Static decode, registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ready <= 1'b0;
      debug_pins_owned <= 1'b0;
      brownout_level_sel <= 1'b1;
      ultra_low_power_brownout <= 1'b0;
      watchdog_mode <= CWD_WDT_ON;
      watchdog_always_on <= 1'b1;
      powerup_timer <= 1'b0;
      master_clear_pin_en <= 1'b1;
    end else begin
      cfg_ready <= run;
      debug_pins_owned <= ~sup_q[CWD_DEBUG_B];
      brownout_level_sel <= sup_q[CWD_BORLVL_B];
      ultra_low_power_brownout <= ~sup_q[CWD_LPBOR_B];
      watchdog_mode <= sup_q[CWD_WDT_B +: 2];
      watchdog_always_on <= (sup_q[CWD_WDT_B +: 2] == CWD_WDT_ON);
      powerup_timer <= ~sup_q[CWD_POWERUP_TIMER_B];
      master_clear_pin_en <= low_volt_prog_en | sup_q[CWD_MASTER_CLEAR_PIN_B];
    end
  end

  // Brown-out enable by mode; software bit matters only in mode 01
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_enable <= 1'b1;
    end else begin
      case (bor_mode)
        CWD_BOR_ON: brownout_enable <= 1'b1;
        CWD_BOR_SLEEP: brownout_enable <= ~sleep_mode;
        CWD_BOR_SW: brownout_enable <= sbor_q;
        default: brownout_enable <= 1'b0;
      endcase
    end
  end

  // Software brown-out enable bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sbor_q <= CWD_SBOR_RST;
    end else if (reg_wr && reg_addr == CWD_REG_CTRL) begin
      sbor_q <= reg_wdata[CWD_CTRL_SBOR_B];
    end
  end

  // Unlock sequence: key1 then key2 arms the next control write only.
  // Any other write in between drops the arming, so a stray write
  // from runaway code cannot open the lock by accident.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key1_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (reg_wr) begin
      key1_q <= (reg_addr == CWD_REG_KEY) && (reg_wdata == CWD_KEY1);
      armed_q <= key1_q && (reg_addr == CWD_REG_KEY) &&
                 (reg_wdata == CWD_KEY2);
    end
  end

  // Pin-map lock; in one-way mode a set after a clear freezes it.
  // A set without a prior clear does not freeze: boot code may set
  // the lock early and still get its single clear/set cycle later.
  logic lock_wr, lock_new;
  assign lock_wr = reg_wr && reg_addr == CWD_REG_CTRL && armed_q && run;
  assign lock_new = reg_wdata[CWD_CTRL_LOCK_B];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_map_lock <= 1'b0;
      cleared_q <= 1'b0;
      frozen_q <= 1'b0;
    end else if (lock_wr && !frozen_q) begin
      pin_map_lock <= lock_new;
      if (once && pin_map_lock && !lock_new) cleared_q <= 1'b1;
      if (once && cleared_q && lock_new) frozen_q <= 1'b1;
    end
  end

  // Stack faults: flags set wins over a software clear
  logic clr_st;
  assign clr_st = reg_wr && reg_addr == CWD_REG_STAT;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      stack_fault_reset <= 1'b0;
    end else begin
      stack_fault_reset <= sup_q[CWD_STACK_B] && run &&
                           (stack_ovf_evt || stack_unf_evt);
      if (sup_q[CWD_STACK_B] && run && stack_ovf_evt) ovf_q <= 1'b1;
      else if (clr_st && reg_wdata[CWD_ST_OVF_B]) ovf_q <= 1'b0;
      if (sup_q[CWD_STACK_B] && run && stack_unf_evt) unf_q <= 1'b1;
      else if (clr_st && reg_wdata[CWD_ST_UNF_B]) unf_q <= 1'b0;
    end
  end

  // Programming session; low-voltage entry only when enabled.
  // Exit has priority so a stuck entry pulse cannot hold a session.
  // The low-voltage flag remembers how the session was entered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_active <= 1'b0;
      lv_sess_q <= 1'b0;
    end else if (prog_exit) begin
      prog_active <= 1'b0;
      lv_sess_q <= 1'b0;
    end else if (!prog_active && run && prog_hv_entry) begin
      prog_active <= 1'b1;
    end else if (!prog_active && run && prog_lv_entry && low_volt_prog_en) begin
      prog_active <= 1'b1;
      lv_sess_q <= 1'b1;
    end
  end

  // Configuration writes from the programming port
  logic lvp_clear;
  assign lvp_clear = (prog_cfg_sel == CWD_REG_MEM[1:0]) &&
                     !prog_cfg_data[CWD_LVP_B];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr_go <= 1'b0;
      cfg_wr_refused <= 1'b0;
    end else begin
      cfg_wr_go <= prog_cfg_wr && prog_active && !(lvp_clear && lv_sess_q);
      cfg_wr_refused <= prog_cfg_wr && prog_active && lvp_clear && lv_sess_q;
    end
  end

  // Self-write gate; programming port writes bypass it entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_wr_go <= 1'b0;
      sw_wr_blocked <= 1'b0;
    end else begin
      sw_wr_go <= sw_wr_req && run && !wp_hit(mem_q[CWD_WRT_B +: 2], sw_wr_addr);
      sw_wr_blocked <= sw_wr_req && run && wp_hit(mem_q[CWD_WRT_B +: 2], sw_wr_addr);
    end
  end

  // External access through the programming port; CPU path untouched.
  // Read data is zeroed here, not at the memory, so a protected word
  // never reaches the port even for one cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_wr_go <= 1'b0;
      ext_rvalid <= 1'b0;
      ext_rdata <= '0;
    end else begin
      ext_wr_go <= ext_wr_req && prog_active && !ext_prot;
      ext_rvalid <= ext_rd_req && prog_active;
      if (ext_rd_req && prog_active) begin
        ext_rdata <= ext_prot ? '0 : ext_rdata_in;
      end
    end
  end

  // Read port; unmapped indices return zero.
  // Data holds until the next read so slow masters may sample late.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == CWD_REG_SUP) reg_rdata <= sup_q;
      else if (reg_addr == CWD_REG_MEM) reg_rdata <= mem_q;
      else if (reg_addr == CWD_REG_CP) reg_rdata <= cp_q;
      else if (reg_addr == CWD_REG_CTRL) reg_rdata <= {12'h000, pin_map_lock, sbor_q};
      else if (reg_addr == CWD_REG_STAT) reg_rdata <= {9'h000, prog_active, frozen_q,
                                                      lv_sess_q, unf_q, ovf_q};
      else reg_rdata <= '0;
    end
  end

  // Checks on the decoded behaviour
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  words_stable_a: assert property (run && $past(run) |-> $stable(sup_q) && $stable(mem_q))
    else $error("configuration word changed after load");
  debug_pins_a: assert property (cfg_ready |-> debug_pins_owned == ~sup_q[CWD_DEBUG_B])
    else $error("debug pin ownership mismatch");
  stack_reset_a: assert property (run && !sup_q[CWD_STACK_B] |=> !stack_fault_reset)
    else $error("stack fault reset while disabled");
  stack_flag_a: assert property (run && sup_q[CWD_STACK_B] && stack_ovf_evt |=> ovf_q && stack_fault_reset)
    else $error("overflow flag or reset missing");
  lock_frozen_a: assert property (frozen_q |=> $stable(pin_map_lock))
    else $error("pin map lock moved while frozen");
  lock_key_a: assert property (!armed_q |=> $stable(pin_map_lock))
    else $error("pin map lock changed without unlock");
  bor_sw_a: assert property (run && bor_mode == CWD_BOR_SW |=> brownout_enable == $past(sbor_q))
    else $error("software brown-out enable not followed");
  bor_on_a: assert property (run && bor_mode == CWD_BOR_ON |=> brownout_enable)
    else $error("brown-out not forced on");
  master_clear_pin_lvp_a: assert property (cfg_ready && low_volt_prog_en |-> master_clear_pin_en)
    else $error("reset pin not master clear under low-voltage mode");
  lvp_refuse_a: assert property (prog_cfg_wr && prog_active && lv_sess_q && lvp_clear |=> cfg_wr_refused && !cfg_wr_go)
    else $error("low-voltage enable cleared in low-voltage session");
  lv_entry_a: assert property (run && !prog_active && !low_volt_prog_en && !prog_hv_entry && !prog_exit |=> !prog_active)
    else $error("low-voltage entry accepted while disabled");
  ext_zero_a: assert property (ext_rd_req && prog_active && ext_prot |=> ext_rvalid && ext_rdata == '0)
    else $error("protected external read returned data");
  wp_boot_a: assert property (sw_wr_req && run && mem_q[1:0] == CWD_WRT_BOOT && sw_wr_addr > CWD_BOOT_TOP |=> sw_wr_go)
    else $error("write above boot block was blocked");
  wp_all_a: assert property (sw_wr_req && run && mem_q[1:0] == 2'h0 |=> sw_wr_blocked && !sw_wr_go)
    else $error("self-write passed under full protection");

  // Static decode of the configuration words, checked once loaded
  bor_level_a: assert property (cfg_ready |-> brownout_level_sel == sup_q[CWD_BORLVL_B])
    else $error("brown-out level select mismatch");
  lp_bor_a: assert property (cfg_ready |-> ultra_low_power_brownout == !sup_q[CWD_LPBOR_B])
    else $error("low-power brown-out enable mismatch");
  wdt_on_a: assert property (cfg_ready && sup_q[3:2] == 2'h3 |-> watchdog_always_on)
    else $error("watchdog not forced on");
  powerup_timer_a: assert property (cfg_ready |-> powerup_timer == !sup_q[CWD_POWERUP_TIMER_B])
    else $error("power-up timer enable mismatch");
  master_clear_pin_port_a: assert property (cfg_ready && !low_volt_prog_en |-> master_clear_pin_en == sup_q[CWD_MASTER_CLEAR_PIN_B])
    else $error("reset pin function mismatch");
  dbg_stable_a: assert property (cfg_ready && $past(cfg_ready) |-> $stable(debug_pins_owned))
    else $error("decoded output moved after load");
  ready_hold_a: assert property (cfg_ready |=> cfg_ready)
    else $error("ready dropped without reset");
  unimp_ones_a: assert property (run |-> (sup_q & CWD_SUP_UNIMP) == CWD_SUP_UNIMP &&
    (mem_q & CWD_MEM_UNIMP) == CWD_MEM_UNIMP && (cp_q & CWD_CP_UNIMP) == CWD_CP_UNIMP)
    else $error("unimplemented bit not one");

  // Brown-out modes other than software control
  bor_off_a: assert property (run && bor_mode == 2'h0 |=> !brownout_enable)
    else $error("brown-out on while disabled");
  bor_sleep_a: assert property (run && bor_mode == CWD_BOR_SLEEP |=> brownout_enable == !$past(sleep_mode))
    else $error("brown-out not gated by sleep");

  // Stack fault, lock and programming-session checks
  unf_flag_a: assert property (run && sup_q[CWD_STACK_B] && stack_unf_evt |=> unf_q && stack_fault_reset)
    else $error("underflow flag or reset missing");
  lock_free_a: assert property (!once |=> !frozen_q)
    else $error("lock frozen without one-way mode");
  hv_entry_a: assert property (run && !prog_active && prog_hv_entry && !prog_exit |=> prog_active)
    else $error("high-voltage entry refused");

  // External port protection, both memory spaces
  ee_zero_a: assert property (ext_rd_req && prog_active && ext_space_ee && ee_prot |=> ext_rdata == '0)
    else $error("protected eeprom read returned data");
  ext_blk_a: assert property (ext_wr_req && prog_active && ext_prot |=> !ext_wr_go)
    else $error("protected external write passed");
  ext_ok_a: assert property (ext_wr_req && prog_active && !ext_prot |=> ext_wr_go)
    else $error("unprotected external write blocked");
  lock_cycle_c: cover property (lock_wr ##[1:20] frozen_q);
  stack_fault_c: cover property (stack_fault_reset);
  refuse_c: cover property (cfg_wr_refused);
  ext_block_c: cover property (ext_rvalid && ext_rdata == '0);
  bor_sleep_c: cover property (run && bor_mode == CWD_BOR_SLEEP && !brownout_enable);
endmodule // cwd_top
`default_nettype wire

//--- dv/config_word_decoder_tb_top.sv
// Self-checking bench for the configuration word decoder top.
// Assumes cwd_pkg and cwd_top are compiled first; one 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module config_word_decoder_tb_top;
  import cwd_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, sleep_mode, ext_space_ee;
  logic [13:0] nv_sup_word, nv_mem_word, nv_cp_word, reg_rdata, prog_cfg_data, ext_rdata_in, ext_rdata, rd_q;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [1:0] prog_cfg_sel, watchdog_mode;
  logic [12:0] sw_wr_addr;
  logic [8:0] pls;
  logic cfg_ready, debug_pins_owned, stack_fault_reset, pin_map_lock, brownout_level_sel, brownout_enable;
  logic ultra_low_power_brownout, watchdog_always_on, powerup_timer, master_clear_pin_en, prog_active;
  logic cfg_wr_go, cfg_wr_refused, sw_wr_go, sw_wr_blocked, ext_wr_go, ext_rvalid;
  int n_fail, n_checks, cyc;
  // Decoded levels packed so one compare covers a whole word
  wire logic [13:0] dec = {5'h00, debug_pins_owned, brownout_level_sel, brownout_enable, ultra_low_power_brownout,
                           watchdog_mode, watchdog_always_on, powerup_timer, master_clear_pin_en};

  // Pulse lines: 0 ovf, 1 unf, 2 hv entry, 3 lv entry, 4 exit, 5 cfg wr, 6 self wr, 7 ext rd, 8 ext wr
  cwd_top cwd_top_inst (
    .clk(clk), .rst_n(rst_n), .nv_sup_word(nv_sup_word), .nv_mem_word(nv_mem_word), .nv_cp_word(nv_cp_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .stack_ovf_evt(pls[0]), .stack_unf_evt(pls[1]), .prog_hv_entry(pls[2]),
    .prog_lv_entry(pls[3]), .prog_exit(pls[4]), .prog_cfg_wr(pls[5]), .prog_cfg_sel(prog_cfg_sel),
    .prog_cfg_data(prog_cfg_data), .sw_wr_req(pls[6]), .sw_wr_addr(sw_wr_addr), .ext_rd_req(pls[7]),
    .ext_wr_req(pls[8]), .ext_space_ee(ext_space_ee), .ext_rdata_in(ext_rdata_in), .cfg_ready(cfg_ready),
    .debug_pins_owned(debug_pins_owned), .stack_fault_reset(stack_fault_reset), .pin_map_lock(pin_map_lock),
    .brownout_level_sel(brownout_level_sel), .brownout_enable(brownout_enable),
    .ultra_low_power_brownout(ultra_low_power_brownout), .watchdog_mode(watchdog_mode),
    .watchdog_always_on(watchdog_always_on), .powerup_timer(powerup_timer),
    .master_clear_pin_en(master_clear_pin_en), .prog_active(prog_active), .cfg_wr_go(cfg_wr_go),
    .cfg_wr_refused(cfg_wr_refused), .sw_wr_go(sw_wr_go), .sw_wr_blocked(sw_wr_blocked),
    .ext_wr_go(ext_wr_go), .ext_rvalid(ext_rvalid), .ext_rdata(ext_rdata)
  );

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is under two hundred cycles; the ceiling only catches hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(posedge clk);
  endtask

  // One-cycle request pulse; answers are settled when it returns
  task automatic pulse(input int i);
    step;
    pls[i] <= 1'b1;
    step;
    pls[i] <= 1'b0;
    #1;
  endtask

  // Words are held across reset so the load edge sees them stable
  task automatic boot(input logic [13:0] s, input logic [13:0] m, input logic [13:0] c);
    step;
    rst_n <= 1'b0;
    nv_sup_word <= s;
    nv_mem_word <= m;
    nv_cp_word <= c;
    repeat (3) step;
    rst_n <= 1'b1;
    repeat (2) step;
    #1 chk({13'h0000, cfg_ready}, 14'h0001);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    step;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step;
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    step;
    reg_addr <= a;
    reg_rd <= 1'b1;
    step;
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask

  // Unlock keys and the control write go back to back, as the arming requires
  task automatic lock_set(input logic v, input logic e);
    step;
    reg_addr <= CWD_REG_KEY;
    reg_wdata <= CWD_KEY1;
    reg_wr <= 1'b1;
    step;
    reg_wdata <= CWD_KEY2;
    step;
    reg_addr <= CWD_REG_CTRL;
    reg_wdata <= {6'h00, v, 1'b1};
    step;
    reg_wr <= 1'b0;
    step;
    #1 chk({13'h0000, pin_map_lock}, {13'h0000, e});
  endtask

  task automatic sw(input logic [12:0] a, input logic b);
    sw_wr_addr <= a;
    pulse(6);
    chk({12'h000, sw_wr_go, sw_wr_blocked}, {12'h000, ~b, b});
  endtask

  task automatic ext_rd(input logic ee, input logic [13:0] din, input logic [13:0] exp);
    ext_space_ee <= ee;
    ext_rdata_in <= din;
    pulse(7);
    chk({13'h0000, ext_rvalid}, 14'h0001);
    chk(ext_rdata, exp);
  endtask

  task automatic ext_wr(input logic ee, input logic go);
    ext_space_ee <= ee;
    pulse(8);
    chk({13'h0000, ext_wr_go}, {13'h0000, go});
  endtask

  task automatic cfgw(input logic [1:0] sel, input logic [13:0] d, input logic [1:0] exp);
    prog_cfg_sel <= sel;
    prog_cfg_data <= d;
    pulse(5);
    chk({12'h000, cfg_wr_go, cfg_wr_refused}, {12'h000, exp});
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, sleep_mode, ext_space_ee, reg_addr, reg_wdata, pls} = '0;
    {nv_sup_word, nv_mem_word, nv_cp_word, prog_cfg_data, ext_rdata_in} = '0;
    {prog_cfg_sel, sw_wr_addr, rd_q} = '0;
    {n_fail, n_checks, cyc} = '0;
    // Software-enable mode, one-way lock, high trip, protected EEPROM only
    boot(14'h184C, 14'h0002, 14'h0001);
    chk(dec, 14'h017E);
    rd(CWD_REG_SUP);
    chk(rd_q, 14'h1D5C);
    rd(CWD_REG_MEM);
    chk(rd_q, 14'h1FFE);
    rd(CWD_REG_CP);
    chk(rd_q, 14'h3FFD);
    rd(3'h7);
    chk(rd_q, 14'h0000);
    nv_sup_word <= 14'h3FFF;
    wr(CWD_REG_SUP, 8'h00);
    rd(CWD_REG_SUP);
    chk(rd_q, 14'h1D5C);
    chk(dec, 14'h017E);
    wr(CWD_REG_CTRL, 8'h00);
    repeat (2) step;
    #1 chk({13'h0000, brownout_enable}, 14'h0000);
    pulse(0);
    chk({13'h0000, stack_fault_reset}, 14'h0001);
    pulse(1);
    chk({13'h0000, stack_fault_reset}, 14'h0001);
    rd(CWD_REG_STAT);
    chk({12'h000, rd_q[1:0]}, 14'h0003);
    wr(CWD_REG_CTRL, 8'h03);
    repeat (2) step;
    #1 chk({13'h0000, pin_map_lock}, 14'h0000);
    lock_set(1'b1, 1'b1);
    lock_set(1'b0, 1'b0);
    lock_set(1'b1, 1'b1);
    lock_set(1'b0, 1'b1);
    sw(13'h01FF, 1'b1);
    sw(13'h0200, 1'b0);
    pulse(3);
    chk({13'h0000, prog_active}, 14'h0000);
    pulse(2);
    chk({13'h0000, prog_active}, 14'h0001);
    ext_rd(1'b0, 14'h2A5C, 14'h2A5C);
    ext_rd(1'b1, 14'h1234, 14'h0000);
    ext_wr(1'b1, 1'b0);
    ext_wr(1'b0, 1'b1);
    cfgw(2'h1, 14'h0000, 2'b10);
    pulse(4);
    // All fields cleared except EEPROM protect, low-voltage programming on, flash protected only
    boot(14'h0000, 14'h2000, 14'h0002);
    chk(dec, 14'h0123);
    pulse(0);
    chk({13'h0000, stack_fault_reset}, 14'h0000);
    sw(13'h1FFF, 1'b1);
    lock_set(1'b1, 1'b1);
    lock_set(1'b0, 1'b0);
    lock_set(1'b1, 1'b1);
    lock_set(1'b0, 1'b0);
    pulse(3);
    chk({13'h0000, prog_active}, 14'h0001);
    cfgw(2'h1, 14'h0000, 2'b01);
    cfgw(2'h0, 14'h0000, 2'b10);
    ext_rd(1'b0, 14'h3FFF, 14'h0000);
    ext_wr(1'b0, 1'b0);
    ext_rd(1'b1, 14'h1555, 14'h1555);
    pulse(4);
    // Blank words: always-on brown-out ignores the software bit
    boot(14'h3FFF, 14'h3FFF, 14'h3FFF);
    chk(dec, 14'h00DD);
    wr(CWD_REG_CTRL, 8'h00);
    repeat (2) step;
    #1 chk({13'h0000, brownout_enable}, 14'h0001);
    sw(13'h0000, 1'b0);
    // Sleep-gated brown-out and half-range self-write protection
    boot(14'h3FBF, 14'h3FFD, 14'h3FFF);
    chk(dec, 14'h00DD);
    sleep_mode <= 1'b1;
    repeat (2) step;
    #1 chk({13'h0000, brownout_enable}, 14'h0000);
    sleep_mode <= 1'b0;
    sw(13'h0FFF, 1'b1);
    sw(13'h1000, 1'b0);
    pulse(2);
    ext_wr(1'b0, 1'b1);
    summarize();
  end
endmodule // config_word_decoder_tb_top
`default_nettype wire
